// ==== shared/thermal_monitor_cfg.svh ====
// Offsets, field positions, reset values and timing for the register bank
`ifndef THERMAL_MONITOR_CFG_SVH
`define THERMAL_MONITOR_CFG_SVH

// Read pointers
`define RA_LOCAL_READING 8'h00
`define RA_REMOTE_READING_HI 8'h01
`define RA_STATUS_FIRST 8'h02
`define RA_CONFIG_FIRST 8'h03
`define RA_CONV_RATE 8'h04
`define RA_LOCAL_UPPER 8'h05
`define RA_LOCAL_LOWER 8'h06
`define RA_REMOTE_UPPER_HI 8'h07
`define RA_REMOTE_LOWER_HI 8'h08
`define RA_REMOTE_READING_LO 8'h10
`define RA_STATUS_SECOND 8'h23
`define RA_SECOND_READING_HI 8'h30
`define RA_SECOND_READING_LO 8'h33
`define RA_MAKER_ID 8'hFE
`define RA_REVISION 8'hFF

// Write pointers that differ from the read pointers
`define WA_CONFIG_FIRST 8'h09
`define WA_CONV_RATE 8'h0A
`define WA_LOCAL_UPPER 8'h0B
`define WA_LOCAL_LOWER 8'h0C
`define WA_REMOTE_UPPER_HI 8'h0D
`define WA_REMOTE_LOWER_HI 8'h0E
`define WA_SINGLE_MEASURE 8'h0F

// Pointers shared by read and write
`define A_REMOTE_OFFSET_HI 8'h11
`define A_REMOTE_OFFSET_LO 8'h12
`define A_REMOTE_UPPER_LO 8'h13
`define A_REMOTE_LOWER_LO 8'h14
`define A_REMOTE_COMP_LIMIT 8'h19
`define A_LOCAL_COMP_LIMIT 8'h20
`define A_COMP_HYSTERESIS 8'h21
`define A_FAULT_FILTER 8'h22
`define A_CONFIG_SECOND 8'h24
`define A_SECOND_UPPER_HI 8'h31
`define A_SECOND_LOWER_HI 8'h32
`define A_SECOND_OFFSET_HI 8'h34
`define A_SECOND_OFFSET_LO 8'h35
`define A_SECOND_UPPER_LO 8'h36
`define A_SECOND_LOWER_LO 8'h37
`define A_SECOND_COMP_LIMIT 8'h39

// Reset values
`define RST_ZERO 8'h00
`define RST_UPPER 8'h55
`define RST_HYSTERESIS 8'h0A
`define RST_CONV_RATE 8'h07
`define RST_FAULT_FILTER 8'h01

// Identity values, arbitrary
`define MAKER_ID_VALUE 8'h5A
`define REVISION_VALUE 8'h01

// Field positions
`define FF_SCL_TIMEOUT 7
`define FF_SDA_TIMEOUT 6
`define FF_MASK_LOCAL 5
`define FF_COUNT_HI 3
`define FF_COUNT_LO 1
`define CFG1_REMOTE_SEL 3
`define ST1_BUSY 7
`define ST2_ALERT 0

// First rate code of the three fastest rates
`define FAST_RATE_FIRST 8'h08

// Timing
`define CLK_MHZ 250
`define BUS_TIMEOUT_MS 25
`define BUS_TIMEOUT_CYCLES (`BUS_TIMEOUT_MS * 1000 * `CLK_MHZ)

`endif

// ==== shared/thermal_monitor_pkg.sv ====
// Types shared by the register bank and its fault filter
package thermal_monitor_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] chan_t;
  typedef enum logic [1:0] {CH_LOCAL, CH_REMOTE1, CH_REMOTE2} chan_e;
endpackage : thermal_monitor_pkg

// ==== shared/fault_filter_if.sv ====
// Carrier between the register bank and the consecutive fault filter
`timescale 1ns/10ps
`default_nettype none
interface fault_filter_if;
  logic meas_done;
  thermal_monitor_pkg::chan_t out_of_limit;
  logic [2:0] count_code;
  thermal_monitor_pkg::chan_t pass;
  modport bank (output meas_done, output out_of_limit, output count_code,
    input pass);
  modport filter (input meas_done, input out_of_limit, input count_code,
    output pass);
endinterface : fault_filter_if
`default_nettype wire

// ==== rtl/fault_filter.sv ====
// Consecutive out-of-limit counter per channel
`timescale 1ns/10ps
`default_nettype none
`include "thermal_monitor_cfg.svh"
module fault_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bank side
  fault_filter_if.filter ffi
);
  logic [1:0] needed;
  // Codes 000,001,011,111 give 1..4; the count is one plus the number of ones
  always_comb begin
    needed = 2'(ffi.count_code[0]) + 2'(ffi.count_code[1])
      + 2'(ffi.count_code[2]);
  end

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic [1:0] seen;
      always_ff @(posedge clk) begin
        if (rst) begin
          seen <= 2'h0;
        end else if (ffi.meas_done) begin
          if (!ffi.out_of_limit[ch]) begin
            seen <= 2'h0;
          end else if (seen != 2'h3) begin
            seen <= seen + 2'h1;
          end
        end
      end
      // Current measurement plus earlier consecutive ones reach the need
      assign ffi.pass[ch] = ffi.out_of_limit[ch]
        && (seen >= needed);
    end
  endgenerate
endmodule : fault_filter
`default_nettype wire

// ==== rtl/thermal_monitor_regs.sv ====
// Register bank of the three-channel temperature monitor
`timescale 1ns/10ps
`default_nettype none
`include "thermal_monitor_cfg.svh"
// How it works
// - Alert needs 1,2,3,4 consecutive out-of-limit results per count code.
// - Filter register resets to 01h, one result raises the alert.
// - Filter top bits enable clock and data line timeouts, reset off.
// - Filter bit 5 keeps local channel flags off the alert output.
// - Averaging is off at the three fastest rates; filter replaces it.
// - Several registers are read at one pointer, written at another.
// - Config one bit 3 steers aliased remote addresses to channel two.
// - Channel two registers also sit at dedicated pointers 30h to 39h.
// - Write to 0Fh starts one measurement; data discarded, unreadable.
// - Power-on loads upper and comparator limits 55h, hysteresis 0Ah, rate 07h, filter 01h, others zero.
// - Bit 7 clock timeout, bit 6 data timeout, release after 25 ms.
// - Eight unmasked alert flags set a latch driving the low alert pin.
// - Single measurement converts all channels, then back to standby.
module thermal_monitor_regs #(
  parameter int unsigned TIMEOUT_CYCLES = `BUS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Byte requests from the serial engine
  input wire logic PTR_WR,
  input wire logic DATA_WR,
  input wire logic [7:0] WDATA,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic RD_VALID,
  // Bus line activity and timeout
  input wire logic SCL_LOW,
  input wire logic SDA_LOW,
  output logic BUS_RELEASE,
  // Measurement results
  input wire logic MEAS_DONE,
  input wire logic CONVERTING,
  input wire logic [7:0] LOCAL_TEMP,
  input wire logic [7:0] R1_TEMP_HI,
  input wire logic [7:0] R1_TEMP_LO,
  input wire logic [7:0] R2_TEMP_HI,
  input wire logic [7:0] R2_TEMP_LO,
  input wire logic D1_OPEN,
  input wire logic D2_OPEN,
  // Control
  input wire logic LOCK,
  input wire logic ALERT_SERVICED,
  output logic SINGLE_START,
  output logic AVERAGE_EN,
  output logic [7:0] CONV_RATE,
  output logic [7:0] CONFIG_FIRST,
  output logic [7:0] CONFIG_SECOND,
  // Alarm pins
  output logic ALERT_N,
  output logic OVERTEMP_N
);
  typedef thermal_monitor_pkg::byte_t byte_t;

  fault_filter_if ffi ();

  byte_t pointer;
  byte_t local_reading;
  byte_t rem_hi [2];
  byte_t rem_lo [2];
  byte_t rem_upper_hi [2];
  byte_t rem_lower_hi [2];
  byte_t rem_upper_lo [2];
  byte_t rem_lower_lo [2];
  byte_t rem_off_hi [2];
  byte_t rem_off_lo [2];
  byte_t rem_comp [2];
  byte_t local_upper;
  byte_t local_lower;
  byte_t local_comp;
  byte_t hysteresis;
  byte_t fault_filter_reg;
  logic [6:2] st1_flags;
  logic [4:2] st2_flags;
  logic [2:0] comp_hit;
  logic alert_latch;
  logic [23:0] idle_count;
  logic sel;
  logic wr;
  byte_t next_rdata;

  assign sel = CONFIG_FIRST[`CFG1_REMOTE_SEL];
  assign wr = DATA_WR && !LOCK;

  // Pointer register, loaded by the first byte of every write
  always_ff @(posedge CLK) begin
    if (RST) begin
      pointer <= `RST_ZERO;
    end else if (PTR_WR) begin
      pointer <= WDATA;
    end
  end

  // Local and shared control registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      CONFIG_FIRST <= `RST_ZERO;
      CONV_RATE <= `RST_CONV_RATE;
      local_upper <= `RST_UPPER;
      local_lower <= `RST_ZERO;
      local_comp <= `RST_UPPER;
      hysteresis <= `RST_HYSTERESIS;
      fault_filter_reg <= `RST_FAULT_FILTER;
      CONFIG_SECOND <= `RST_ZERO;
    end else if (wr) begin
      if (pointer == `WA_CONFIG_FIRST) begin
        CONFIG_FIRST <= WDATA;
      end else if (pointer == `WA_CONV_RATE) begin
        CONV_RATE <= WDATA;
      end else if (pointer == `WA_LOCAL_UPPER) begin
        local_upper <= WDATA;
      end else if (pointer == `WA_LOCAL_LOWER) begin
        local_lower <= WDATA;
      end else if (pointer == `A_LOCAL_COMP_LIMIT) begin
        local_comp <= WDATA;
      end else if (pointer == `A_COMP_HYSTERESIS) begin
        hysteresis <= WDATA;
      end else if (pointer == `A_FAULT_FILTER) begin
        fault_filter_reg <= WDATA;
      end else if (pointer == `A_CONFIG_SECOND) begin
        CONFIG_SECOND <= WDATA;
      end
    end
  end

  // Remote limit, offset and comparator registers, one set per channel
  genvar rc;
  generate
    for (rc = 0; rc < 2; rc++) begin : g_remote
      logic alias_hit;
      logic own_hit;
      // Aliased pointers reach this channel only when the select matches
      assign alias_hit = (sel == 1'(rc));
      assign own_hit = (rc == 1);
      always_ff @(posedge CLK) begin
        if (RST) begin
          rem_upper_hi[rc] <= `RST_UPPER;
          rem_lower_hi[rc] <= `RST_ZERO;
          rem_upper_lo[rc] <= `RST_ZERO;
          rem_lower_lo[rc] <= `RST_ZERO;
          rem_off_hi[rc] <= `RST_ZERO;
          rem_off_lo[rc] <= `RST_ZERO;
          rem_comp[rc] <= `RST_UPPER;
        end else if (wr) begin
          if ((alias_hit && pointer == `WA_REMOTE_UPPER_HI)
              || (own_hit && pointer == `A_SECOND_UPPER_HI)) begin
            rem_upper_hi[rc] <= WDATA;
          end else if ((alias_hit && pointer == `WA_REMOTE_LOWER_HI)
              || (own_hit && pointer == `A_SECOND_LOWER_HI)) begin
            rem_lower_hi[rc] <= WDATA;
          end else if ((alias_hit && pointer == `A_REMOTE_UPPER_LO)
              || (own_hit && pointer == `A_SECOND_UPPER_LO)) begin
            rem_upper_lo[rc] <= WDATA;
          end else if ((alias_hit && pointer == `A_REMOTE_LOWER_LO)
              || (own_hit && pointer == `A_SECOND_LOWER_LO)) begin
            rem_lower_lo[rc] <= WDATA;
          end else if ((alias_hit && pointer == `A_REMOTE_OFFSET_HI)
              || (own_hit && pointer == `A_SECOND_OFFSET_HI)) begin
            rem_off_hi[rc] <= WDATA;
          end else if ((alias_hit && pointer == `A_REMOTE_OFFSET_LO)
              || (own_hit && pointer == `A_SECOND_OFFSET_LO)) begin
            rem_off_lo[rc] <= WDATA;
          end else if ((alias_hit && pointer == `A_REMOTE_COMP_LIMIT)
              || (own_hit && pointer == `A_SECOND_COMP_LIMIT)) begin
            rem_comp[rc] <= WDATA;
          end
        end
      end
    end
  endgenerate

  // Readings captured at the end of each measurement, never locked
  always_ff @(posedge CLK) begin
    if (RST) begin
      local_reading <= `RST_ZERO;
      rem_hi[0] <= `RST_ZERO;
      rem_lo[0] <= `RST_ZERO;
      rem_hi[1] <= `RST_ZERO;
      rem_lo[1] <= `RST_ZERO;
    end else if (MEAS_DONE) begin
      local_reading <= LOCAL_TEMP;
      rem_hi[0] <= R1_TEMP_HI;
      rem_lo[0] <= R1_TEMP_LO;
      rem_hi[1] <= R2_TEMP_HI;
      rem_lo[1] <= R2_TEMP_LO;
    end
  end

  // Limit comparisons on the fresh measurement
  logic lhigh, llow, r1high, r1low, r2high, r2low;
  assign lhigh = LOCAL_TEMP > local_upper;
  assign llow = LOCAL_TEMP < local_lower;
  assign r1high = {R1_TEMP_HI, R1_TEMP_LO[7:6]}
    > {rem_upper_hi[0], rem_upper_lo[0][7:6]};
  assign r1low = {R1_TEMP_HI, R1_TEMP_LO[7:6]}
    < {rem_lower_hi[0], rem_lower_lo[0][7:6]};
  assign r2high = {R2_TEMP_HI, R2_TEMP_LO[7:6]}
    > {rem_upper_hi[1], rem_upper_lo[1][7:6]};
  assign r2low = {R2_TEMP_HI, R2_TEMP_LO[7:6]}
    < {rem_lower_hi[1], rem_lower_lo[1][7:6]};

  assign ffi.meas_done = MEAS_DONE;
  assign ffi.out_of_limit = {r2high | r2low | D2_OPEN,
    r1high | r1low | D1_OPEN, lhigh | llow};
  assign ffi.count_code =
    fault_filter_reg[`FF_COUNT_HI:`FF_COUNT_LO];

  fault_filter u_filter (
    .clk(CLK),
    .rst(RST),
    .ffi(ffi.filter)
  );

  logic rd_st1, rd_st2;
  assign rd_st1 = RD && pointer == `RA_STATUS_FIRST;
  assign rd_st2 = RD && pointer == `RA_STATUS_SECOND;

  // Sticky flags; a fresh set beats the clear-on-read
  always_ff @(posedge CLK) begin
    if (RST) begin
      st1_flags <= 5'h00;
      st2_flags <= 3'h0;
    end else begin
      if (MEAS_DONE && ffi.pass[thermal_monitor_pkg::CH_LOCAL]) begin
        st1_flags[6:5] <= st1_flags[6:5] | {lhigh, llow};
      end else if (rd_st1) begin
        st1_flags[6:5] <= 2'h0;
      end
      if (MEAS_DONE && ffi.pass[thermal_monitor_pkg::CH_REMOTE1]) begin
        st1_flags[4:2] <= st1_flags[4:2] | {r1high, r1low, D1_OPEN};
      end else if (rd_st1) begin
        st1_flags[4:2] <= 3'h0;
      end
      if (MEAS_DONE && ffi.pass[thermal_monitor_pkg::CH_REMOTE2]) begin
        st2_flags <= st2_flags | {r2high, r2low, D2_OPEN};
      end else if (rd_st2) begin
        st2_flags <= 3'h0;
      end
    end
  end

  // Alert latch: set by any unmasked flag, cleared when serviced and idle
  logic alert_src;
  assign alert_src = (|st1_flags[4:2]) | (|st2_flags)
    | ((|st1_flags[6:5])
       && !fault_filter_reg[`FF_MASK_LOCAL]);
  always_ff @(posedge CLK) begin
    if (RST) begin
      alert_latch <= 1'b0;
    end else if (alert_src) begin
      alert_latch <= 1'b1;
    end else if (ALERT_SERVICED) begin
      alert_latch <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ALERT_N <= 1'b1;
    end else begin
      ALERT_N <= !alert_latch;
    end
  end

  // Comparator flags with hysteresis on the way down
  byte_t comp_temp [3];
  byte_t comp_lim [3];
  assign comp_temp[0] = LOCAL_TEMP;
  assign comp_temp[1] = R1_TEMP_HI;
  assign comp_temp[2] = R2_TEMP_HI;
  assign comp_lim[0] = local_comp;
  assign comp_lim[1] = rem_comp[0];
  assign comp_lim[2] = rem_comp[1];
  genvar cc;
  generate
    for (cc = 0; cc < 3; cc++) begin : g_comp
      always_ff @(posedge CLK) begin
        if (RST) begin
          comp_hit[cc] <= 1'b0;
        end else if (MEAS_DONE) begin
          if (comp_temp[cc] > comp_lim[cc]) begin
            comp_hit[cc] <= 1'b1;
          end else if ({1'b0, comp_temp[cc]} + {1'b0, hysteresis}
                       <= {1'b0, comp_lim[cc]}) begin
            comp_hit[cc] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge CLK) begin
    if (RST) begin
      OVERTEMP_N <= 1'b1;
    end else begin
      OVERTEMP_N <= !(|comp_hit);
    end
  end

  // Write to the single-measure pointer: pulse only, nothing stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      SINGLE_START <= 1'b0;
    end else begin
      SINGLE_START <= DATA_WR
        && pointer == `WA_SINGLE_MEASURE;
    end
  end

  // No averaging at the three fastest rates
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVERAGE_EN <= 1'b1;
    end else begin
      AVERAGE_EN <= CONV_RATE < `FAST_RATE_FIRST;
    end
  end

  // Bus timeout on a line held low while its enable is set
  logic stuck;
  assign stuck = (SCL_LOW && fault_filter_reg[`FF_SCL_TIMEOUT])
    || (SDA_LOW && fault_filter_reg[`FF_SDA_TIMEOUT]);
  always_ff @(posedge CLK) begin
    if (RST) begin
      idle_count <= 24'h000000;
      BUS_RELEASE <= 1'b0;
    end else if (!stuck) begin
      idle_count <= 24'h000000;
      BUS_RELEASE <= 1'b0;
    end else if (idle_count == 24'(TIMEOUT_CYCLES - 1)) begin
      idle_count <= 24'h000000;
      BUS_RELEASE <= 1'b1;
    end else begin
      idle_count <= idle_count + 24'h000001;
      BUS_RELEASE <= 1'b0;
    end
  end

  // Read decode; write-only and unmapped pointers read zero
  always_comb begin
    next_rdata = `RST_ZERO;
    if (pointer == `RA_LOCAL_READING) begin
      next_rdata = local_reading;
    end else if (pointer == `RA_REMOTE_READING_HI) begin
      next_rdata = rem_hi[sel];
    end else if (pointer == `RA_STATUS_FIRST) begin
      next_rdata = {CONVERTING, st1_flags, comp_hit[1], comp_hit[0]};
    end else if (pointer == `RA_CONFIG_FIRST) begin
      next_rdata = CONFIG_FIRST;
    end else if (pointer == `RA_CONV_RATE) begin
      next_rdata = CONV_RATE;
    end else if (pointer == `RA_LOCAL_UPPER) begin
      next_rdata = local_upper;
    end else if (pointer == `RA_LOCAL_LOWER) begin
      next_rdata = local_lower;
    end else if (pointer == `RA_REMOTE_UPPER_HI) begin
      next_rdata = rem_upper_hi[sel];
    end else if (pointer == `RA_REMOTE_LOWER_HI) begin
      next_rdata = rem_lower_hi[sel];
    end else if (pointer == `RA_REMOTE_READING_LO) begin
      next_rdata = rem_lo[sel];
    end else if (pointer == `A_REMOTE_OFFSET_HI) begin
      next_rdata = rem_off_hi[sel];
    end else if (pointer == `A_REMOTE_OFFSET_LO) begin
      next_rdata = rem_off_lo[sel];
    end else if (pointer == `A_REMOTE_UPPER_LO) begin
      next_rdata = rem_upper_lo[sel];
    end else if (pointer == `A_REMOTE_LOWER_LO) begin
      next_rdata = rem_lower_lo[sel];
    end else if (pointer == `A_REMOTE_COMP_LIMIT) begin
      next_rdata = rem_comp[sel];
    end else if (pointer == `A_LOCAL_COMP_LIMIT) begin
      next_rdata = local_comp;
    end else if (pointer == `A_COMP_HYSTERESIS) begin
      next_rdata = hysteresis;
    end else if (pointer == `A_FAULT_FILTER) begin
      next_rdata = fault_filter_reg;
    end else if (pointer == `RA_STATUS_SECOND) begin
      next_rdata = {3'h0, st2_flags, comp_hit[2], alert_latch};
    end else if (pointer == `A_CONFIG_SECOND) begin
      next_rdata = CONFIG_SECOND;
    end else if (pointer == `RA_SECOND_READING_HI) begin
      next_rdata = rem_hi[1];
    end else if (pointer == `A_SECOND_UPPER_HI) begin
      next_rdata = rem_upper_hi[1];
    end else if (pointer == `A_SECOND_LOWER_HI) begin
      next_rdata = rem_lower_hi[1];
    end else if (pointer == `RA_SECOND_READING_LO) begin
      next_rdata = rem_lo[1];
    end else if (pointer == `A_SECOND_OFFSET_HI) begin
      next_rdata = rem_off_hi[1];
    end else if (pointer == `A_SECOND_OFFSET_LO) begin
      next_rdata = rem_off_lo[1];
    end else if (pointer == `A_SECOND_UPPER_LO) begin
      next_rdata = rem_upper_lo[1];
    end else if (pointer == `A_SECOND_LOWER_LO) begin
      next_rdata = rem_lower_lo[1];
    end else if (pointer == `A_SECOND_COMP_LIMIT) begin
      next_rdata = rem_comp[1];
    end else if (pointer == `RA_MAKER_ID) begin
      next_rdata = `MAKER_ID_VALUE;
    end else if (pointer == `RA_REVISION) begin
      next_rdata = `REVISION_VALUE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= `RST_ZERO;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD;
      if (RD) begin
        RDATA <= next_rdata;
      end
    end
  end
endmodule : thermal_monitor_regs
`default_nettype wire

// ==== verif/host_model.sv ====
// Host model driving the register byte port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Register byte port
  input wire logic clk,
  output var logic ptr_wr,
  output var logic data_wr,
  output var logic [7:0] wdata,
  output var logic rd_req,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial begin
    ptr_wr = 0;
    data_wr = 0;
    wdata = 8'h00;
    rd_req = 0;
  end
  // Pointer byte then data byte; caller picks write pointer
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    @(negedge clk);
    ptr_wr = 1;
    wdata = p;
    @(negedge clk);
    ptr_wr = 0;
    data_wr = 1;
    wdata = v;
    @(negedge clk);
    data_wr = 0;
    wdata = ~v;
  endtask : wr
  // Pointer byte then read; caller picks read pointer
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    @(negedge clk);
    ptr_wr = 1;
    wdata = p;
    @(negedge clk);
    ptr_wr = 0;
    rd_req = 1;
    wdata = ~p;
    @(negedge clk);
    rd_req = 0;
    d = (rd_valid === 1'b1) ? rdata : 8'hXX;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ==== verif/thermal_monitor_properties.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module thermal_monitor_properties #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Observed ports
  input wire logic PTR_WR,
  input wire logic DATA_WR,
  input wire logic [7:0] WDATA,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic RD_VALID,
  input wire logic SCL_LOW,
  input wire logic SDA_LOW,
  input wire logic BUS_RELEASE,
  input wire logic MEAS_DONE,
  input wire logic ALERT_SERVICED,
  input wire logic SINGLE_START,
  input wire logic AVERAGE_EN,
  input wire logic [7:0] CONV_RATE,
  input wire logic ALERT_N
);
  wire stuck = SCL_LOW | SDA_LOW;
  int unsigned run;
  // Length of the current stuck-line stretch
  always_ff @(posedge CLK) begin
    if (RST || !stuck) run <= 0;
    else run <= run + 1;
  end
  sequence trig_ptr;
    PTR_WR && WDATA == 8'h0F;
  endsequence
  sequence trig_wr;
    trig_ptr ##1 DATA_WR;
  endsequence
  sequence trig_rd;
    trig_ptr ##1 RD;
  endsequence
  a_start_on_trigger: assert property (@(posedge CLK) disable iff (RST)
    trig_wr |=> SINGLE_START) else $error("single start missing");
  a_start_needs_write: assert property (@(posedge CLK) disable iff (RST)
    SINGLE_START |-> $past(DATA_WR)) else $error("stray single start");
  a_trigger_reads_zero: assert property (@(posedge CLK) disable iff (RST)
    trig_rd |=> RD_VALID && RDATA == 8'h00) else $error("trigger readable");
  a_read_answer: assert property (@(posedge CLK) disable iff (RST)
    RD |=> RD_VALID) else $error("read not answered");
  a_avg_off_fast: assert property (@(posedge CLK) disable iff (RST)
    CONV_RATE >= 8'h08 [*2] |-> !AVERAGE_EN) else $error("averaging fast");
  a_avg_on_slow: assert property (@(posedge CLK) disable iff (RST)
    CONV_RATE < 8'h08 [*2] |-> AVERAGE_EN) else $error("averaging off");
  a_alert_by_meas: assert property (@(posedge CLK) disable iff (RST)
    $fell(ALERT_N) |-> $past(MEAS_DONE, 3)) else $error("alert no cause");
  a_alert_release: assert property (@(posedge CLK) disable iff (RST)
    $rose(ALERT_N) |-> $past(ALERT_SERVICED, 2) || $past(ALERT_SERVICED))
    else $error("alert released unserviced");
  a_release_late: assert property (@(posedge CLK) disable iff (RST)
    BUS_RELEASE |-> run >= TIMEOUT_CYCLES - 1) else $error("release early");
  a_release_pulse: assert property (@(posedge CLK) disable iff (RST)
    BUS_RELEASE |=> !BUS_RELEASE) else $error("release not a pulse");
  a_reset_values: assert property (@(posedge CLK)
    RST |=> ALERT_N && CONV_RATE == 8'h07 && !SINGLE_START)
    else $error("reset values wrong");
endmodule : thermal_monitor_properties
bind thermal_monitor_regs thermal_monitor_properties #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.CLK(CLK), .RST(RST),
  .PTR_WR(PTR_WR), .DATA_WR(DATA_WR), .WDATA(WDATA), .RD(RD),
  .RDATA(RDATA), .RD_VALID(RD_VALID), .SCL_LOW(SCL_LOW),
  .SDA_LOW(SDA_LOW), .BUS_RELEASE(BUS_RELEASE), .MEAS_DONE(MEAS_DONE),
  .ALERT_SERVICED(ALERT_SERVICED), .SINGLE_START(SINGLE_START),
  .AVERAGE_EN(AVERAGE_EN), .CONV_RATE(CONV_RATE), .ALERT_N(ALERT_N));
`default_nettype wire

// ==== verif/tb_thermal_monitor_register_map.sv ====
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
`include "thermal_monitor_cfg.svh"
module tb_thermal_monitor_register_map;
  logic clk = 0, rst = 1, scl_low = 0, sda_low = 0, meas_done = 0;
  logic conv = 0, d1_open = 0, d2_open = 0, lock = 0, serviced = 0;
  logic ptr_wr, data_wr, rd, rd_valid, rel, start, avg, alert_n, ot_n;
  logic [7:0] wdata, rdata, rate, cfg1, cfg2, d;
  logic [7:0] lt = 0, r1h = 0, r2h = 0, r1l = 0, r2l = 0;
  int err_total = 0, checks = 0, starts = 0, rels = 0;
  thermal_monitor_regs #(.TIMEOUT_CYCLES(20)) DUT (
    .CLK(clk), .RST(rst), .PTR_WR(ptr_wr), .DATA_WR(data_wr),
    .WDATA(wdata), .RD(rd), .RDATA(rdata), .RD_VALID(rd_valid),
    .SCL_LOW(scl_low), .SDA_LOW(sda_low), .BUS_RELEASE(rel),
    .MEAS_DONE(meas_done), .CONVERTING(conv), .LOCAL_TEMP(lt),
    .R1_TEMP_HI(r1h), .R1_TEMP_LO(r1l), .R2_TEMP_HI(r2h),
    .R2_TEMP_LO(r2l), .D1_OPEN(d1_open), .D2_OPEN(d2_open),
    .LOCK(lock), .ALERT_SERVICED(serviced), .SINGLE_START(start),
    .AVERAGE_EN(avg), .CONV_RATE(rate), .CONFIG_FIRST(cfg1),
    .CONFIG_SECOND(cfg2), .ALERT_N(alert_n), .OVERTEMP_N(ot_n));
  host_model host (.clk(clk), .ptr_wr(ptr_wr), .data_wr(data_wr),
    .wdata(wdata), .rd_req(rd), .rdata(rdata), .rd_valid(rd_valid));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (rel === 1'b1) rels++;
  end
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic meas(logic [7:0] l, logic [7:0] a, logic [7:0] b);
    @(negedge clk);
    meas_done = 1;
    lt = l;
    r1h = a;
    r2h = b;
    @(negedge clk);
    meas_done = 0;
    repeat (2) @(negedge clk);
  endtask : meas
  task automatic clr();
    d1_open = 0;
    meas(8'h20, 8'h20, 8'h20);
    host.rd(8'h02, d);
    host.rd(8'h23, d);
    @(negedge clk) serviced = 1;
    @(negedge clk) serviced = 0;
    repeat (2) @(negedge clk);
    chk1("alert_n cleared", 1, alert_n);
    chk1("overtemp_n clear", 1, ot_n);
  endtask : clr
  task automatic t_defaults();
    logic [15:0] tbl [13] = '{16'h0300, 16'h0407, 16'h0555, 16'h0600,
      16'h0755, 16'h1955, 16'h2055, 16'h210A, 16'h2201, 16'h2300,
      16'h3155, 16'h3955, {8'hFE, `MAKER_ID_VALUE}};
    foreach (tbl[i]) begin
      host.rd(tbl[i][15:8], d);
      chk8("default", tbl[i][7:0], d);
    end
    chk8("conv_rate", 8'h07, rate);
    $display("done defaults");
  endtask : t_defaults
  task automatic t_filter();
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h22, {4'h0, codes[i], 1'h1});
      for (int k = 1; k <= i + 1; k++) begin
        meas(8'h60, 8'h20, 8'h20);
        chk1("alert_n count", k <= i, alert_n);
      end
      clr();
    end
    host.wr(8'h22, 8'h20);
    meas(8'h60, 8'h20, 8'h20);
    chk1("alert_n masked", 1, alert_n);
    chk1("overtemp_n set", 0, ot_n);
    d1_open = 1;
    meas(8'h20, 8'h20, 8'h20);
    chk1("alert_n remote", 0, alert_n);
    clr();
    $display("done filter");
  endtask : t_filter
  task automatic stuck(logic scl, logic [7:0] ff, logic [7:0] n);
    int r;
    host.wr(8'h22, ff);
    r = rels;
    scl_low = scl;
    sda_low = !scl;
    repeat (30) @(negedge clk);
    scl_low = 0;
    sda_low = 0;
    repeat (2) @(negedge clk);
    chk8("releases", n, 8'(rels - r));
  endtask : stuck
  task automatic t_rate_single();
    int s;
    stuck(1, 8'h01, 0);
    stuck(1, 8'h81, 1);
    stuck(0, 8'h41, 1);
    stuck(0, 8'h81, 0);
    host.wr(8'h0A, 8'h08);
    @(negedge clk);
    chk1("average_en fast", 0, avg);
    host.wr(8'h0A, 8'h07);
    @(negedge clk);
    chk1("average_en slow", 1, avg);
    s = starts;
    host.wr(8'h0F, 8'hA5);
    @(negedge clk);
    chk8("single starts", 1, 8'(starts - s));
    host.rd(8'h0F, d);
    chk8("trigger read", 8'h00, d);
    lock = 1;
    host.wr(8'h0B, 8'h11);
    host.rd(8'h05, d);
    chk8("locked limit", 8'h55, d);
    host.wr(8'h24, 8'hC3);
    chk8("locked config_second", 8'h00, cfg2);
    host.wr(8'h0F, 8'h00);
    @(negedge clk);
    chk8("locked start", 2, 8'(starts - s));
    lock = 0;
    $display("done rate_single");
  endtask : t_rate_single
  task automatic t_alias();
    meas(8'h20, 8'h21, 8'h2D);
    host.rd(8'h01, d);
    chk8("remote sel 0", 8'h21, d);
    host.wr(8'h0D, 8'h3C);
    host.wr(8'h07, 8'h11);
    host.rd(8'h07, d);
    chk8("split limit", 8'h3C, d);
    host.rd(8'h0D, d);
    chk8("write ptr read", 8'h00, d);
    host.wr(8'h09, 8'h08);
    chk8("config_first", 8'h08, cfg1);
    host.rd(8'h01, d);
    chk8("remote sel 1", 8'h2D, d);
    host.wr(8'h0D, 8'h4B);
    host.rd(8'h31, d);
    chk8("second limit", 8'h4B, d);
    host.wr(8'h09, 8'h00);
    host.rd(8'h07, d);
    chk8("first limit", 8'h3C, d);
    host.rd(8'h30, d);
    chk8("second reading", 8'h2D, d);
    $display("done alias");
  endtask : t_alias
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_defaults();
    t_filter();
    t_rate_single();
    t_alias();
    stop_test();
  end
  // Run needs a few hundred cycles; far longer means a hang
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : tb_thermal_monitor_register_map
`default_nettype wire
